// ===== verilog/pbc_pkg.sv
package pbc_pkg;
    // register byte offsets
    localparam int REG_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BIT_LIMIT = 8'h04;
    localparam logic [7:0] OFF_ERR_LIMIT = 8'h08;
    localparam logic [7:0] OFF_BIT_COUNT = 8'h0C;
    localparam logic [7:0] OFF_ERR_COUNT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
    // control fields
    localparam int CTRL_W = 7;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_POLY_LSB = 1;
    localparam int POLY_W = 3;
    localparam int CTRL_INTEG = 4;
    localparam int CTRL_QUAL_EN = 5;
    localparam int CTRL_QUAL_POL = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    // status fields
    localparam int STAT_W = 7;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SYNC = 1;
    localparam int STAT_DONE = 2;
    localparam int STAT_END_BITS = 3;
    localparam int STAT_END_ERRS = 4;
    localparam int STAT_DISCARD = 5;
    localparam int STAT_WAIT_QUERY = 6;
    // interrupt events
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DISCARD = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    // polynomial codes
    localparam logic [POLY_W-1:0] POLY_PN9 = 3'h0;
    localparam logic [POLY_W-1:0] POLY_PN11 = 3'h1;
    localparam logic [POLY_W-1:0] POLY_PN15 = 3'h2;
    localparam logic [POLY_W-1:0] POLY_PN16 = 3'h3;
    localparam logic [POLY_W-1:0] POLY_PN20 = 3'h4;
    localparam logic [POLY_W-1:0] POLY_PN21 = 3'h5;
    localparam logic [POLY_W-1:0] POLY_PN23 = 3'h6;
    // degrees and taps
    localparam int DEG_PN9 = 9, TAP_PN9 = 4;
    localparam int DEG_PN11 = 11, TAP_PN11 = 2;
    localparam int DEG_PN15 = 15, TAP_PN15 = 1;
    localparam int DEG_PN16 = 16, TAP_PN16_A = 5, TAP_PN16_B = 3, TAP_PN16_C = 2;
    localparam int DEG_PN20 = 20, TAP_PN20 = 3;
    localparam int DEG_PN21 = 21, TAP_PN21 = 2;
    localparam int DEG_PN23 = 23, TAP_PN23 = 5;
    localparam int LFSR_W = 23;
    localparam int FILL_W = 5;
    localparam int SYNC_MAX_BITS = 24;
    // error share above 1/4 marks a false lock
    localparam int BAD_SHIFT = 2;
    localparam logic [31:0] BIT_LIM_RST = 32'h0001_0000;
    localparam logic [31:0] ERR_LIM_RST = 32'h0000_0064;

    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_CHECK, ST_DONE} pbc_meas_state_t;

    function automatic logic [FILL_W-1:0] pbc_degree(input logic [POLY_W-1:0] p);
        logic [FILL_W-1:0] d;
        d = FILL_W'(DEG_PN9);
        case (p)
            POLY_PN11: d = FILL_W'(DEG_PN11);
            POLY_PN15: d = FILL_W'(DEG_PN15);
            POLY_PN16: d = FILL_W'(DEG_PN16);
            POLY_PN20: d = FILL_W'(DEG_PN20);
            POLY_PN21: d = FILL_W'(DEG_PN21);
            POLY_PN23: d = FILL_W'(DEG_PN23);
            default: d = FILL_W'(DEG_PN9);
        endcase
        return d;
    endfunction : pbc_degree

    function automatic logic pbc_inverted(input logic [POLY_W-1:0] p);
        return (p == POLY_PN15) || (p == POLY_PN23);
    endfunction : pbc_inverted

    function automatic logic pbc_feedback(input logic [LFSR_W-1:0] s, input logic [POLY_W-1:0] p);
        logic fb;
        fb = s[DEG_PN9-1] ^ s[TAP_PN9-1];
        case (p)
            POLY_PN11: fb = s[DEG_PN11-1] ^ s[TAP_PN11-1];
            POLY_PN15: fb = s[DEG_PN15-1] ^ s[TAP_PN15-1];
            POLY_PN16: fb = s[DEG_PN16-1] ^ s[TAP_PN16_A-1] ^ s[TAP_PN16_B-1] ^ s[TAP_PN16_C-1];
            POLY_PN20: fb = s[DEG_PN20-1] ^ s[TAP_PN20-1];
            POLY_PN21: fb = s[DEG_PN21-1] ^ s[TAP_PN21-1];
            POLY_PN23: fb = s[DEG_PN23-1] ^ s[TAP_PN23-1];
            default: fb = s[DEG_PN9-1] ^ s[TAP_PN9-1];
        endcase
        return fb;
    endfunction : pbc_feedback
endpackage : pbc_pkg

// ===== verilog/pbc_link_if.sv
// sampled link bits passed from the pin sampler to the checker core
interface pbc_link_if;
    logic bit_stb;
    logic bit_data;
    logic bit_qual;
    logic restart;
    modport src (output bit_stb, output bit_data, output bit_qual, output restart);
    modport dst (input bit_stb, input bit_data, input bit_qual, input restart);
endinterface : pbc_link_if

// ===== verilog/pbc_link_sampler.sv
// pin synchronisers and bit clock edge finder
module pbc_link_sampler import pbc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    // link pins
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic data_valid_qualifier,
    input wire logic restart_pin,
    // sampled bits
    pbc_link_if.src link
);
    typedef struct packed {
        logic [1:0] clk_s;
        logic clk_old;
        logic [1:0] dat_s;
        logic [1:0] qual_s;
        logic [1:0] rst_s;
        logic stb;
        logic data;
        logic qual;
        logic restart;
    } pbc_smp_t;

    pbc_smp_t s, n;

    always_comb begin
        n = s;
        // first stages feed only the second stages
        n.clk_s = {s.clk_s[0], link_clk};
        n.dat_s = {s.dat_s[0], link_data};
        n.qual_s = {s.qual_s[0], data_valid_qualifier};
        n.rst_s = {s.rst_s[0], restart_pin};
        n.clk_old = s.clk_s[1];
        n.stb = s.clk_s[1] & ~s.clk_old;
        if (s.clk_s[1] & ~s.clk_old) begin
            n.data = s.dat_s[1];
            n.qual = s.qual_s[1];
        end
        n.restart = s.rst_s[1];
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign link.bit_stb = s.stb;
    assign link.bit_data = s.data;
    assign link.bit_qual = s.qual;
    assign link.restart = s.restart;
endmodule : pbc_link_sampler

// ===== verilog/pbc_checker.sv
// pseudo-random bit error rate checker with register port
//
// The register offsets and the strobed register port are this design's own decisions.
module pbc_checker import pbc_pkg::*; #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // link pins
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic data_valid_qualifier,
    input wire logic restart_pin,
    // interrupt
    output logic irq
);
    if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
        $error("pbc_checker: CNT_W must lie in 8..32");
    end

    typedef struct packed {
        pbc_meas_state_t st;
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] bit_lim;
        logic [CNT_W-1:0] err_lim;
        logic [CNT_W-1:0] bit_cnt;
        logic [CNT_W-1:0] err_cnt;
        logic [LFSR_W-1:0] lfsr;
        logic [FILL_W-1:0] fill;
        logic end_bits;
        logic end_errs;
        logic discard;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] imask;
        logic [31:0] rdata;
        logic irq;
    } pbc_core_t;

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;
    pbc_core_t s, n;
    pbc_link_if link();

    // reset released through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    pbc_link_sampler u_sampler (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .link_clk(link_clk),
        .link_data(link_data),
        .data_valid_qualifier(data_valid_qualifier),
        .restart_pin(restart_pin),
        .link(link)
    );

    logic [POLY_W-1:0] poly;
    logic [FILL_W-1:0] deg;
    logic run;
    logic hold;
    logic qualified;
    logic bit_ok;
    logic rx_bit;
    logic expect_bit;
    logic mismatch;
    logic bad_result;
    logic query;
    logic [STAT_W-1:0] status;

    assign poly = s.ctrl[CTRL_POLY_LSB +: POLY_W];
    assign deg = pbc_degree(poly);
    assign run = s.ctrl[CTRL_RUN];
    // restart high holds the run in integrating mode
    assign hold = s.ctrl[CTRL_INTEG] & link.restart;
    // qualifier level selectable high or low
    assign qualified = ~s.ctrl[CTRL_QUAL_EN] | (link.bit_qual == s.ctrl[CTRL_QUAL_POL]);
    assign bit_ok = link.bit_stb & qualified & ~hold;
    // undo the standard's inversion before comparing
    assign rx_bit = link.bit_data ^ pbc_inverted(poly);
    assign expect_bit = pbc_feedback(s.lfsr, poly);
    assign mismatch = rx_bit ^ expect_bit;
    // false lock shows as a large error share
    assign bad_result = s.err_cnt > (s.bit_cnt >> BAD_SHIFT);
    // reading the error count is the result query
    assign query = reg_rd && (reg_addr == OFF_ERR_COUNT);

    always_comb begin
        status = '0;
        status[STAT_BUSY] = (s.st == ST_FILL) || (s.st == ST_CHECK);
        status[STAT_SYNC] = (s.st == ST_FILL);
        status[STAT_DONE] = (s.st == ST_DONE);
        status[STAT_END_BITS] = s.end_bits;
        status[STAT_END_ERRS] = s.end_errs;
        status[STAT_DISCARD] = s.discard;
        status[STAT_WAIT_QUERY] = (s.st == ST_DONE);
    end

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [CNT_W-1:0] bits_nx;
        logic [CNT_W-1:0] errs_nx;
        ev = '0;
        bits_nx = s.bit_cnt + CNT_W'(1);
        errs_nx = s.err_cnt + CNT_W'(mismatch);
        n = s;
        n.rdata = '0;
        // restart pulse drops back to filling
        if (hold && ((s.st == ST_FILL) || (s.st == ST_CHECK))) begin
            n.st = ST_FILL;
            n.fill = '0;
        end else if (bit_ok && (s.st == ST_FILL)) begin
            n.lfsr = {s.lfsr[LFSR_W-2:0], rx_bit};
            n.fill = s.fill + FILL_W'(1);
            if (s.fill == deg - FILL_W'(1)) begin
                n.st = ST_CHECK;
            end
        end else if (bit_ok && (s.st == ST_CHECK)) begin
            n.lfsr = {s.lfsr[LFSR_W-2:0], expect_bit};
            n.bit_cnt = bits_nx;
            n.err_cnt = errs_nx;
            // either limit ends and is recorded
            n.end_bits = bits_nx >= s.bit_lim;
            n.end_errs = errs_nx >= s.err_lim;
            if (n.end_bits || n.end_errs) begin
                n.st = ST_DONE;
                ev[IRQ_DONE] = 1'b1;
            end
        end
        if (query && (s.st == ST_DONE)) begin
            n.st = run ? ST_FILL : ST_IDLE;
            n.fill = '0;
            n.bit_cnt = '0;
            n.err_cnt = '0;
            n.end_bits = 1'b0;
            n.end_errs = 1'b0;
            n.discard = bad_result;
            ev[IRQ_DISCARD] = bad_result;
        end
        if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL: begin
                    n.ctrl = reg_wdata[CTRL_W-1:0];
                    if (!reg_wdata[CTRL_RUN]) begin
                        n.st = ST_IDLE;
                    end else if (!run) begin
                        // fresh start resyncs from the first bit
                        n.st = ST_FILL;
                        n.fill = '0;
                        n.bit_cnt = '0;
                        n.err_cnt = '0;
                        n.end_bits = 1'b0;
                        n.end_errs = 1'b0;
                        n.discard = 1'b0;
                    end
                end
                OFF_BIT_LIMIT: n.bit_lim = reg_wdata[CNT_W-1:0];
                OFF_ERR_LIMIT: n.err_lim = reg_wdata[CNT_W-1:0];
                OFF_IRQ_MASK: n.imask = reg_wdata[IRQ_W-1:0];
                default: n.imask = n.imask;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL: n.rdata = 32'(s.ctrl);
                OFF_BIT_LIMIT: n.rdata = 32'(s.bit_lim);
                OFF_ERR_LIMIT: n.rdata = 32'(s.err_lim);
                OFF_BIT_COUNT: n.rdata = 32'(s.bit_cnt);
                OFF_ERR_COUNT: n.rdata = 32'(s.err_cnt);
                OFF_STATUS: n.rdata = 32'(status);
                OFF_IRQ_STAT: n.rdata = 32'(s.istat);
                OFF_IRQ_MASK: n.rdata = 32'(s.imask);
                default: n.rdata = '0;
            endcase
        end
        // an event in the clearing read survives it
        if (reg_rd && (reg_addr == OFF_IRQ_STAT)) begin
            n.istat = ev;
        end else begin
            n.istat = s.istat | ev;
        end
        n.irq = |(n.istat & n.imask);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s.st <= ST_IDLE;
            s.ctrl <= CTRL_RST;
            s.bit_lim <= BIT_LIM_RST[CNT_W-1:0];
            s.err_lim <= ERR_LIM_RST[CNT_W-1:0];
            s.bit_cnt <= '0;
            s.err_cnt <= '0;
            s.lfsr <= '0;
            s.fill <= '0;
            s.end_bits <= 1'b0;
            s.end_errs <= 1'b0;
            s.discard <= 1'b0;
            s.istat <= '0;
            s.imask <= IRQ_MASK_RST;
            s.rdata <= '0;
            s.irq <= 1'b0;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign irq = s.irq;

    // checks on the measurement sequence
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence seq_fill_bit;
        (s.st == ST_FILL) && bit_ok && !reg_wr;
    endsequence

    sequence seq_check_bit;
        (s.st == ST_CHECK) && bit_ok && !reg_wr && !query;
    endsequence

    sequence seq_query_done;
        query && (s.st == ST_DONE) && !reg_wr;
    endsequence

    a_hold_until_query: assert property (
        (s.st == ST_DONE) && !query && !reg_wr |=> (s.st == ST_DONE) && $stable(s.err_cnt)
    ) else $error("result left before query");

    a_sync_bound: assert property (
        (s.st == ST_FILL) |-> (s.fill < deg) && (32'(deg) <= SYNC_MAX_BITS)
    ) else $error("fill runs past polynomial degree");

    a_fill_length: assert property (
        seq_fill_bit ##0 (s.fill == deg - FILL_W'(1)) |=> (s.st == ST_CHECK) && $stable(s.err_cnt)
    ) else $error("fill did not end after degree bits");

    a_no_err_fill: assert property (
        (s.st == ST_FILL) && !reg_wr |=> (s.err_cnt == $past(s.err_cnt)) && (s.bit_cnt == $past(s.bit_cnt))
    ) else $error("counts moved while filling");

    a_discard_bad: assert property (
        seq_query_done ##0 bad_result ##0 run |=> s.discard && (s.st == ST_FILL) && s.istat[IRQ_DISCARD]
    ) else $error("false lock not discarded and repeated");

    a_compare_count: assert property (
        seq_check_bit ##0 (n.st == ST_CHECK) |=>
            (s.err_cnt == $past(s.err_cnt) + CNT_W'($past(rx_bit) ^ $past(expect_bit))) &&
            (s.lfsr[0] == $past(expect_bit))
    ) else $error("compare against prediction wrong");

    a_invert_expect: assert property (
        seq_check_bit ##0 ((poly == POLY_PN15) || (poly == POLY_PN23)) |->
            (mismatch == (link.bit_data == expect_bit))
    ) else $error("inverted standard not inverted");

    a_qual_gate: assert property (
        link.bit_stb && !qualified && !reg_wr && !query |=> $stable(s.lfsr) && $stable(s.bit_cnt)
    ) else $error("unqualified bit was counted");

    a_restart_hold: assert property (
        hold && ((s.st == ST_FILL) || (s.st == ST_CHECK)) && !reg_wr |=>
            (s.st == ST_FILL) && (s.fill == '0) && $stable(s.bit_cnt) && $stable(s.err_cnt)
    ) else $error("restart did not hold the run");

    a_end_limit: assert property (
        seq_check_bit ##0 ((s.bit_cnt + CNT_W'(1)) >= s.bit_lim) |=>
            (s.st == ST_DONE) && s.end_bits ##1 s.irq == (s.imask[IRQ_DONE] || $past(s.irq))
    ) else $error("bit limit did not end measurement");
endmodule : pbc_checker

// ===== verification/pbc_dut_model.sv
// behavioural far side: returns bit clock, prbs data, qualifier and restart
module pbc_dut_model (
    // test controls
    input wire logic run,
    input wire logic [2:0] poly,
    input wire logic gaps,
    input wire logic qual_pol,
    input wire logic signed [31:0] flip_at,
    input wire logic signed [31:0] brk_at,
    // link pins
    output logic link_clk,
    output logic link_data,
    output logic data_valid_qualifier,
    output logic restart_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [22:0] s_q;
    logic b;
    logic use_bit;
    int idx;

    function automatic logic fb(input logic [22:0] r, input logic [2:0] p);
        case (p)
            3'h1: return r[10] ^ r[1];
            3'h2: return r[14] ^ r[0];
            3'h3: return r[15] ^ r[4] ^ r[2] ^ r[1];
            3'h4: return r[19] ^ r[2];
            3'h5: return r[20] ^ r[1];
            3'h6: return r[22] ^ r[4];
            default: return r[8] ^ r[3];
        endcase
    endfunction : fb

    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
        data_valid_qualifier = 1'b0;
        restart_pin = 1'b0;
        forever begin
            // released line must not keep its last level
            link_data = ~link_data;
            restart_pin = 1'b0;
            s_q = '1;
            idx = 0;
            wait (run);
            while (run) begin
                use_bit = !gaps || idx[0];
                // restart pulse at the start of a broken-off sequence
                restart_pin = (idx == brk_at) || (idx == brk_at + 1);
                if (idx == brk_at) begin
                    s_q = 23'h0000AA;
                end
                b = fb(s_q, poly);
                if (use_bit) begin
                    s_q = {s_q[21:0], b};
                end
                link_data = b ^ !use_bit ^ (poly == 3'h2 || poly == 3'h6) ^ (idx == flip_at);
                data_valid_qualifier = (use_bit == qual_pol);
                idx++;
                // exactly one rising edge per bit
                #160 link_clk = 1'b1;
                #160 link_clk = 1'b0;
            end
        end
    end
endmodule : pbc_dut_model

// ===== verification/testbench.sv
// self-checking bench for the bit error rate checker
module testbench import pbc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic link_clk, link_data, data_valid_qualifier, restart_pin, irq;
    logic m_run = 1'b0, m_gaps = 1'b0, m_qpol = 1'b1;
    logic [2:0] m_poly = 3'h0;
    int m_flip = -10, m_brk = -10;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    logic [31:0] rv;
    logic [7:0] ra [8] = '{OFF_CTRL, OFF_BIT_LIMIT, OFF_ERR_LIMIT, OFF_IRQ_MASK, OFF_STATUS, OFF_BIT_COUNT,
        OFF_ERR_COUNT, 8'h20};
    logic [31:0] re [8] = '{32'h0, BIT_LIM_RST, ERR_LIM_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    initial begin
        forever begin
            #20 sys_clk = ~sys_clk;
        end
    end

    pbc_checker #(.CNT_W(32)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk), .link_data(link_data),
        .data_valid_qualifier(data_valid_qualifier), .restart_pin(restart_pin), .irq(irq));
    pbc_dut_model far_end (.run(m_run), .poly(m_poly), .gaps(m_gaps), .qual_pol(m_qpol), .flip_at(m_flip),
        .brk_at(m_brk), .link_clk(link_clk), .link_data(link_data),
        .data_valid_qualifier(data_valid_qualifier), .restart_pin(restart_pin));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s, got %h", $time, what, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        rd(a);
        chk(rv & m, e, what);
    endtask : rdc

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        rv = '0;
        while (rv[STAT_DONE] !== 1'b1 && n < lim) begin
            rd(OFF_STATUS);
            n++;
        end
        chk({31'h0, rv[STAT_DONE]}, 32'h1, "measurement end");
    endtask : wait_done

    task automatic start(input logic [31:0] ctrl, input logic [2:0] mp, input logic [31:0] bl,
        input logic [31:0] el);
        wr(OFF_BIT_LIMIT, bl);
        wr(OFF_ERR_LIMIT, el);
        wr(OFF_CTRL, ctrl);
        @(posedge sys_clk);
        m_poly <= mp;
        m_run <= 1'b1;
        wait_done(400);
    endtask : start

    // idle the checker before the link goes quiet
    task automatic stop;
        wr(OFF_CTRL, 32'h0);
        // stale events would hide a missing irq next time
        rd(OFF_IRQ_STAT);
        @(posedge sys_clk);
        m_run <= 1'b0;
        m_flip <= -10;
        m_brk <= -10;
        m_gaps <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask : stop

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        foreach (ra[i]) rdc(ra[i], '1, re[i], "reset value");
        wr(OFF_IRQ_MASK, 32'h1);
        for (int p = 0; p < 7; p++) begin
            start(32'h1 | (p << 1), 3'(p), 32'h28, 32'h64);
            chk({31'h0, irq}, 32'h1, "irq on end");
            if (p == 0) begin
                repeat (192) @(posedge sys_clk);
                rdc(OFF_BIT_COUNT, '1, 32'h28, "held until query");
            end
            rdc(OFF_STATUS, 32'h7E, 32'h4C, "end by bit limit");
            rdc(OFF_BIT_COUNT, '1, 32'h28, "bits after fill");
            rdc(OFF_IRQ_STAT, '1, 32'h1, "done event");
            chk({31'h0, irq}, 32'h0, "irq cleared");
            rdc(OFF_ERR_COUNT, '1, 32'h0, "clean sequence");
            if (p == 0) begin
                // 9 bits to lock plus 40 checked, 8 clocks a bit
                wait_done(270);
                rdc(OFF_ERR_COUNT, '1, 32'h0, "resynchronised");
            end
            stop;
        end
        m_flip <= 15;
        start(32'h1, 3'h0, 32'h28, 32'h64);
        rdc(OFF_ERR_COUNT, '1, 32'h1, "single flipped bit");
        stop;
        wr(OFF_IRQ_MASK, 32'h3);
        m_flip <= 3;
        start(32'h1, 3'h0, 32'h28, 32'h64);
        rd(OFF_ERR_COUNT);
        rdc(OFF_STATUS, 32'h20, 32'h20, "result discarded");
        rdc(OFF_IRQ_STAT, '1, 32'h3, "done and discard events");
        wait_done(400);
        rdc(OFF_ERR_COUNT, '1, 32'h0, "repeat is clean");
        rdc(OFF_STATUS, 32'h20, 32'h0, "discard flag cleared");
        stop;
        wr(OFF_IRQ_MASK, 32'h0);
        start(32'h1, 3'h1, 32'hC8, 32'h0A);
        chk({31'h0, irq}, 32'h0, "masked event");
        rdc(OFF_STATUS, 32'h7E, 32'h54, "end by error limit");
        rdc(OFF_IRQ_STAT, '1, 32'h1, "masked event kept");
        rdc(OFF_IRQ_STAT, '1, 32'h0, "read clears events");
        rdc(OFF_ERR_COUNT, '1, 32'h0A, "error limit count");
        stop;
        for (int q = 0; q < 2; q++) begin
            m_gaps <= 1'b1;
            m_qpol <= 1'(q);
            start(32'h21 | (q << 6), 3'h0, 32'h28, 32'h64);
            rdc(OFF_BIT_COUNT, '1, 32'h28, "qualified bits only");
            rdc(OFF_ERR_COUNT, '1, 32'h0, "unqualified bits skipped");
            stop;
        end
        m_brk <= 20;
        start(32'h11, 3'h0, 32'h28, 32'h64);
        rdc(OFF_BIT_COUNT, '1, 32'h28, "counts accumulate");
        rdc(OFF_ERR_COUNT, '1, 32'h0, "restart at break");
        stop;
        m_brk <= 20;
        start(32'h1, 3'h0, 32'h28, 32'h64);
        rd(OFF_ERR_COUNT);
        chk({31'h0, rv != 32'h0}, 32'h1, "break without restart");
        stop;
        tally_and_finish;
    end
endmodule : testbench
